// ===== rtl/pin_function_and_powerdown.v
`timescale 1ns/1ps
`include "pin_function_map.vh"

module pin_function_and_powerdown (
    // clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // power-down and straps from the host side pins
    input wire power_down_n_input_in,
    input wire config_strap_a_in,
    input wire config_strap_b_in,
    // self-test pins
    input wire self_test_enable_input_in,
    input wire shared_pin_in,
    input wire self_test_error_in,
    // register-side configuration
    input wire shared_pin_sel_in,
    input wire int_pulldown_req_in,
    input wire dual_link_in,
    input wire [4:0] gp_sel_in,
    input wire [4:0] gp_data_in,
    input wire [4:0] gp_dir_in,
    input wire [3:0] fast_sel_in,
    input wire [3:0] fast_data_in,
    input wire [3:0] fast_dir_in,
    input wire [3:0] spi_data_in,
    input wire [3:0] spi_dir_in,
    input wire [3:0] reg_only_sel_in,
    input wire [3:0] reg_only_data_in,
    // audio sources from the audio block
    input wire [4:0] gp_audio_in,
    input wire audio_slave_word_clock_in,
    input wire audio_slave_bit_clock_in,
    input wire audio_slave_data_a_in,
    input wire audio_slave_data_b_in,
    // gp pins: bit order zero, one, two, three, nine
    input wire [4:0] gp_pin_in,
    output reg [4:0] gp_pin_out,
    output reg [4:0] gp_pin_oe_out,
    // fast pins: bit order zero to three
    input wire [3:0] fast_pin_in,
    output reg [3:0] fast_pin_out,
    output reg [3:0] fast_pin_oe_out,
    // register-only pins: bit order five to eight
    output reg [3:0] reg_only_pin_out,
    output reg [3:0] reg_only_pin_oe_out,
    // shared interrupt pin drive
    output reg interrupt_input_n_out,
    output reg interrupt_input_n_oe_out,
    // status
    output reg enabled_out,
    output reg pll_run_out,
    output reg self_test_mode_out,
    output reg self_test_clk_sel_out,
    output reg interrupt_req_out,
    output reg pass_out,
    output reg [1:0] strap_cfg_out,
    output reg [4:0] gp_pin_level_out,
    output reg [3:0] fast_pin_level_out
);
    // pin levels are asynchronous to the recovered clock
    wire [4:0] ctl_sync;
    wire [4:0] gp_sync;
    wire [3:0] fast_sync;
    wire pd_n_s;
    wire strap_a_s;
    wire strap_b_s;
    wire bist_en_s;
    wire shared_s;
    wire pass_w;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg run_r;
    reg [1:0] strap_r;

    level_sync #(.WIDTH(5)) ctl_sync_u (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({power_down_n_input_in, config_strap_a_in,
            config_strap_b_in, self_test_enable_input_in, shared_pin_in}),
        .sync_out(ctl_sync)
    );

    level_sync #(.WIDTH(9)) pin_sync_u (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({gp_pin_in, fast_pin_in}),
        .sync_out({gp_sync, fast_sync})
    );

    assign pd_n_s = ctl_sync[4];
    assign strap_a_s = ctl_sync[3];
    assign strap_b_s = ctl_sync[2];
    assign bist_en_s = ctl_sync[1];
    assign shared_s = ctl_sync[0];

    // wake state gives one cycle where everything but strap_cfg_out (holds strap_r) and the interrupt pull-down is forced to defaults
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `ST_DOWN: begin
                if (pd_n_s)
                    state_nxt = `ST_WAKE;
            end
            `ST_WAKE: begin
                state_nxt = pd_n_s ? `ST_RUN : `ST_DOWN;
            end
            `ST_RUN: begin
                if (!pd_n_s)
                    state_nxt = `ST_DOWN;
            end
            default: begin
                state_nxt = `ST_DOWN;
            end
        endcase
    end

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= `ST_DOWN;
            run_r <= 1'b0;
            strap_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            run_r <= (state_nxt == `ST_RUN);
            // straps caught once at each release and held through power-down until the next release
            if (state_r == `ST_WAKE)
                strap_r <= {strap_b_s, strap_a_s};
        end
    end

    self_test_check check_u (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(run_r),
        .enable_in(bist_en_s),
        .error_in(self_test_error_in),
        .pass_out(pass_w)
    );

    // pin muxing; outputs reset to defaults and float while down, except strap_cfg_out (holds strap_r) and the interrupt pull-down
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gp_pin_out <= `GP_OUT_RESET;
            gp_pin_oe_out <= 5'h00;
            fast_pin_out <= 4'h0;
            fast_pin_oe_out <= `FAST_OE_RESET;
            reg_only_pin_out <= `REG_ONLY_OUT_RESET;
            reg_only_pin_oe_out <= 4'h0;
            interrupt_input_n_out <= 1'b0;
            interrupt_input_n_oe_out <= 1'b0;
            enabled_out <= 1'b0;
            pll_run_out <= 1'b0;
            self_test_mode_out <= 1'b0;
            self_test_clk_sel_out <= `SELF_TEST_CLK_PIXEL;
            interrupt_req_out <= 1'b0;
            pass_out <= 1'b1;
            strap_cfg_out <= 2'h0;
            gp_pin_level_out <= 5'h00;
            fast_pin_level_out <= 4'h0;
        end else if (!run_r) begin
            gp_pin_out <= `GP_OUT_RESET;
            gp_pin_oe_out <= 5'h00;
            fast_pin_out <= 4'h0;
            fast_pin_oe_out <= `FAST_OE_RESET;
            reg_only_pin_out <= `REG_ONLY_OUT_RESET;
            reg_only_pin_oe_out <= 4'h0;
            interrupt_input_n_out <= 1'b0;
            // only the interrupt pin may pull low while powered down
            interrupt_input_n_oe_out <= !pd_n_s && int_pulldown_req_in;
            enabled_out <= 1'b0;
            pll_run_out <= 1'b0;
            self_test_mode_out <= 1'b0;
            self_test_clk_sel_out <= `SELF_TEST_CLK_PIXEL;
            interrupt_req_out <= 1'b0;
            pass_out <= 1'b1;
            strap_cfg_out <= strap_r;
            gp_pin_level_out <= 5'h00;
            fast_pin_level_out <= 4'h0;
        end else begin
            enabled_out <= 1'b1;
            pll_run_out <= 1'b1;
            strap_cfg_out <= strap_r;
            self_test_mode_out <= bist_en_s;
            interrupt_input_n_out <= 1'b0;
            interrupt_input_n_oe_out <= 1'b0;
            // shared pin: interrupt by default, clock select on request
            if (shared_pin_sel_in == `SHARED_PIN_SELF_TEST) begin
                interrupt_req_out <= 1'b0;
                self_test_clk_sel_out <= shared_s;
            end else begin
                interrupt_req_out <= !shared_s;
                self_test_clk_sel_out <= `SELF_TEST_CLK_PIXEL;
            end
            pass_out <= pass_w;
            // gp pins: gpio by default, audio role by select
            gp_pin_out <= (gp_sel_in & gp_audio_in)
                | (~gp_sel_in & gp_data_in);
            gp_pin_oe_out <= gp_sel_in | gp_dir_in;
            gp_pin_level_out <= gp_sync;
            // fast pins only work with both links up
            if (dual_link_in) begin
                fast_pin_out <= (fast_sel_in & spi_data_in)
                    | (~fast_sel_in & fast_data_in);
                fast_pin_oe_out <= (fast_sel_in & spi_dir_in)
                    | (~fast_sel_in & fast_dir_in);
                fast_pin_level_out <= fast_sync;
            end else begin
                fast_pin_out <= 4'h0;
                fast_pin_oe_out <= `FAST_OE_RESET;
                fast_pin_level_out <= 4'h0;
            end
            // register-only pins are outputs driven low unless set
            reg_only_pin_oe_out <= 4'hf;
            reg_only_pin_out[`AUD_DB_BIT] <= reg_only_sel_in[`AUD_DB_BIT] ?
                audio_slave_data_b_in : reg_only_data_in[`AUD_DB_BIT];
            reg_only_pin_out[`AUD_DA_BIT] <= reg_only_sel_in[`AUD_DA_BIT] ?
                audio_slave_data_a_in : reg_only_data_in[`AUD_DA_BIT];
            reg_only_pin_out[`AUD_WC_BIT] <= reg_only_sel_in[`AUD_WC_BIT] ?
                audio_slave_word_clock_in : reg_only_data_in[`AUD_WC_BIT];
            // bit clock needs the jitter cleaner off upstream
            reg_only_pin_out[`AUD_CLK_BIT] <= reg_only_sel_in[`AUD_CLK_BIT] ?
                audio_slave_bit_clock_in : reg_only_data_in[`AUD_CLK_BIT];
        end
    end
endmodule // pin_function_and_powerdown

// ===== rtl/pin_function_map.vh
`ifndef PIN_FUNCTION_MAP_VH
`define PIN_FUNCTION_MAP_VH

// function select codes for the gp and register-only pins
`define SEL_GPIO 1'b0
`define SEL_AUDIO 1'b1
// self-test clock source select levels
`define SELF_TEST_CLK_PIXEL 1'b0
`define SELF_TEST_CLK_33M 1'b1
// shared pin function select
`define SHARED_PIN_INT 1'b0
`define SHARED_PIN_SELF_TEST 1'b1
// reset values
`define GP_OUT_RESET 5'h00
`define REG_ONLY_OUT_RESET 4'h0
`define FAST_OE_RESET 4'h0
// bit positions of the slave audio roles on the register-only pins
`define AUD_DB_BIT 0
`define AUD_DA_BIT 1
`define AUD_WC_BIT 2
`define AUD_CLK_BIT 3
// power-up sequencer states
`define ST_DOWN 2'h0
`define ST_WAKE 2'h1
`define ST_RUN 2'h2

`endif

// ===== rtl/level_sync.v
`timescale 1ns/1ps
// two-flop synchroniser for a bus of pin levels
module level_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // level_sync

// ===== rtl/self_test_check.v
`timescale 1ns/1ps
// sticky self-test error tracker; pass is high until an error is seen
module self_test_check (
    // clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // control
    input wire run_in,
    input wire enable_in,
    input wire error_in,
    // status
    output reg pass_out
);
    always @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pass_out <= 1'b1;
        end else if (!run_in || !enable_in) begin
            pass_out <= 1'b1;
        end else if (error_in) begin
            pass_out <= 1'b0;
        end
    end
endmodule // self_test_check

// ===== tb/pin_checker_monitor.sv
`timescale 1ns/1ps
module pin_checker_monitor (
    input wire core_clk_in, sys_rst_in, power_down_n_input_in,
    input wire int_pulldown_req_in, dual_link_in, shared_pin_in,
    input wire shared_pin_sel_in, audio_slave_word_clock_in,
    input wire audio_slave_bit_clock_in, audio_slave_data_a_in,
    input wire audio_slave_data_b_in,
    input wire [4:0] gp_sel_in, gp_data_in, gp_audio_in,
    input wire [4:0] gp_pin_out, gp_pin_oe_out,
    input wire [3:0] fast_sel_in, fast_dir_in, spi_dir_in, fast_pin_oe_out,
    input wire [3:0] reg_only_sel_in, reg_only_data_in,
    input wire [3:0] reg_only_pin_out, reg_only_pin_oe_out,
    input wire interrupt_input_n_out, interrupt_input_n_oe_out,
    input wire enabled_out, pll_run_out, self_test_clk_sel_out,
    input wire interrupt_req_out,
    input wire [1:0] strap_cfg_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // pin values one edge behind their selects
    wire [4:0] gp_exp = (gp_sel_in & gp_audio_in) | (~gp_sel_in & gp_data_in);
    wire [3:0] aud = {audio_slave_bit_clock_in, audio_slave_word_clock_in,
        audio_slave_data_a_in, audio_slave_data_b_in};
    wire [3:0] ro_exp = (reg_only_sel_in & aud)
        | (~reg_only_sel_in & reg_only_data_in);
    wire [3:0] fo_exp = dual_link_in ?
        ((fast_sel_in & spi_dir_in) | (~fast_sel_in & fast_dir_in)) : 4'h0;
    sequence pd_held;
        !power_down_n_input_in[*7];
    endsequence
    sequence woke;
        $rose(power_down_n_input_in) ##1 power_down_n_input_in[*7];
    endsequence
    sequence running;
        enabled_out && $past(enabled_out);
    endsequence
    // synced pin levels need a few edges to settle
    sequence settled;
        (enabled_out && $stable(shared_pin_in)
            && $stable(shared_pin_sel_in))[*5];
    endsequence
    pd_float_a: assert property (pd_held |-> !enabled_out
        && !pll_run_out && gp_pin_oe_out == 5'h00
        && fast_pin_oe_out == 4'h0 && reg_only_pin_oe_out == 4'h0)
        else $error("outputs driven in power-down");
    wake_run_a: assert property (woke |-> enabled_out && pll_run_out)
        else $error("not enabled after power-down release");
    int_pull_a: assert property (pd_held ##0
        (int_pulldown_req_in && $past(int_pulldown_req_in))
        |-> interrupt_input_n_oe_out && !interrupt_input_n_out)
        else $error("interrupt pin not pulled low");
    gp_mux_a: assert property (running |-> gp_pin_out == $past(gp_exp))
        else $error("gp pin value wrong");
    fast_oe_a: assert property (running |-> fast_pin_oe_out == $past(fo_exp))
        else $error("fast pin enable wrong");
    reg_only_a: assert property (running |-> reg_only_pin_oe_out == 4'hf
        && reg_only_pin_out == $past(ro_exp))
        else $error("register-only pin wrong");
    shared_pin_a: assert property (settled |->
        self_test_clk_sel_out == (shared_pin_sel_in & shared_pin_in)
        && interrupt_req_out == (!shared_pin_sel_in && !shared_pin_in))
        else $error("shared pin function wrong");
    strap_hold_a: assert property (running |-> $stable(strap_cfg_out))
        else $error("strap changed while running");
endmodule // pin_checker_monitor

bind pin_function_and_powerdown pin_checker_monitor mon (.*);

// ===== tb/host_model.sv
`timescale 1ns/1ps
// host side: power-down line and strap dividers, changed after an edge
module host_model (
    input wire core_clk_in,
    input wire pd_req_in,
    input wire [1:0] strap_req_in,
    output reg pd_n_out,
    output reg [1:0] strap_out
);
    // power-down stays low from power-up until the host releases it
    initial pd_n_out = 1'h0;
    initial strap_out = 2'h0;
    always @(posedge core_clk_in) begin
        pd_n_out <= pd_req_in;
        strap_out <= strap_req_in;
    end
endmodule // host_model

// ===== tb/pin_function_and_powerdown_tb.sv
`timescale 1ns/1ps
module pin_function_and_powerdown_tb;
    logic core_clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic pd_req = 1'h0;
    logic [1:0] strap_req = 2'h0;
    logic self_test_enable_input_in, shared_pin_in, self_test_error_in;
    logic shared_pin_sel_in, int_pulldown_req_in, dual_link_in;
    logic [4:0] gp_sel_in, gp_data_in, gp_dir_in, gp_audio_in, gp_pin_in;
    logic [3:0] fast_sel_in, fast_data_in, fast_dir_in, spi_data_in;
    logic [3:0] spi_dir_in, reg_only_sel_in, reg_only_data_in, fast_pin_in;
    logic audio_slave_word_clock_in, audio_slave_bit_clock_in;
    logic audio_slave_data_a_in, audio_slave_data_b_in;
    wire power_down_n_input_in, config_strap_a_in, config_strap_b_in;
    wire [4:0] gp_pin_out, gp_pin_oe_out, gp_pin_level_out;
    wire [3:0] fast_pin_out, fast_pin_oe_out, fast_pin_level_out;
    wire [3:0] reg_only_pin_out, reg_only_pin_oe_out;
    wire interrupt_input_n_out, interrupt_input_n_oe_out, enabled_out;
    wire pll_run_out, self_test_mode_out, self_test_clk_sel_out;
    wire interrupt_req_out, pass_out;
    wire [1:0] strap_cfg_out;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #25 core_clk_in = ~core_clk_in;
    host_model host (.core_clk_in(core_clk_in), .pd_req_in(pd_req),
        .strap_req_in(strap_req), .pd_n_out(power_down_n_input_in),
        .strap_out({config_strap_b_in, config_strap_a_in}));
    pin_function_and_powerdown dut (.*);
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task at_edge;
        @(posedge core_clk_in);
    endtask
    task wt(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task tally_and_finish;
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial begin
        {self_test_enable_input_in, shared_pin_in, self_test_error_in,
            shared_pin_sel_in, int_pulldown_req_in, dual_link_in, gp_sel_in,
            gp_data_in, gp_dir_in, gp_audio_in, gp_pin_in, fast_sel_in,
            fast_data_in, fast_dir_in, spi_data_in, spi_dir_in, fast_pin_in,
            reg_only_sel_in, reg_only_data_in, audio_slave_word_clock_in,
            audio_slave_bit_clock_in, audio_slave_data_a_in,
            audio_slave_data_b_in} = '0;
        repeat (3) at_edge;
        sys_rst_in <= 1'h0;
        int_pulldown_req_in <= 1'h1;
        strap_req <= 2'h1;
        gp_dir_in <= 5'h1f;
        fast_dir_in <= 4'hf;
        wt(8);
        chk("gp_oe", 8'h00, gp_pin_oe_out);
        chk("pll", 8'h00, pll_run_out);
        chk("int_oe", 8'h01, interrupt_input_n_oe_out);
        at_edge;
        pd_req <= 1'h1;
        wt(8);
        chk("enabled", 8'h01, enabled_out);
        chk("strap", 8'h01, strap_cfg_out);
        chk("gp_out", 8'h00, gp_pin_out);
        chk("ro_out", 8'h00, reg_only_pin_out);
        chk("fast_oe", 8'h00, fast_pin_oe_out);
        at_edge;
        strap_req <= 2'h2;
        gp_data_in <= 5'h15;
        gp_sel_in <= 5'h0a;
        gp_audio_in <= 5'h0a;
        gp_pin_in <= 5'h13;
        fast_pin_in <= 4'h9;
        dual_link_in <= 1'h1;
        fast_sel_in <= 4'h5;
        spi_dir_in <= 4'h1;
        spi_data_in <= 4'h1;
        fast_data_in <= 4'h6;
        reg_only_sel_in <= 4'h3;
        reg_only_data_in <= 4'h9;
        audio_slave_word_clock_in <= 1'h1;
        audio_slave_data_a_in <= 1'h1;
        wt(6);
        chk("strap", 8'h01, strap_cfg_out);
        chk("gp_out", 8'h1f, gp_pin_out);
        chk("gp_oe", 8'h1f, gp_pin_oe_out);
        chk("gp_lvl", 8'h13, gp_pin_level_out);
        chk("fast_lvl", 8'h09, fast_pin_level_out);
        chk("fast_oe", 8'h0b, fast_pin_oe_out);
        chk("fast_out", 8'h03, fast_pin_out);
        chk("ro_out", 8'h0a, reg_only_pin_out);
        at_edge;
        self_test_enable_input_in <= 1'h1;
        shared_pin_sel_in <= 1'h1;
        shared_pin_in <= 1'h1;
        // bit clock role taken only after the jitter cleaner is off
        reg_only_sel_in <= 4'hf;
        audio_slave_bit_clock_in <= 1'h1;
        wt(6);
        chk("ro_out", 8'h0e, reg_only_pin_out);
        chk("st_mode", 8'h01, self_test_mode_out);
        chk("clk_sel", 8'h01, self_test_clk_sel_out);
        chk("pass", 8'h01, pass_out);
        at_edge;
        shared_pin_in <= 1'h0;
        wt(6);
        chk("clk_sel", 8'h00, self_test_clk_sel_out);
        at_edge;
        shared_pin_sel_in <= 1'h0;
        self_test_error_in <= 1'h1;
        at_edge;
        self_test_error_in <= 1'h0;
        wt(6);
        chk("int_req", 8'h01, interrupt_req_out);
        chk("pass", 8'h00, pass_out);
        at_edge;
        self_test_enable_input_in <= 1'h0;
        wt(6);
        chk("st_mode", 8'h00, self_test_mode_out);
        chk("pass", 8'h01, pass_out);
        at_edge;
        pd_req <= 1'h0;
        wt(8);
        chk("enabled", 8'h00, enabled_out);
        chk("ro_oe", 8'h00, reg_only_pin_oe_out);
        at_edge;
        pd_req <= 1'h1;
        wt(8);
        chk("strap", 8'h02, strap_cfg_out);
        tally_and_finish;
    end
endmodule // pin_function_and_powerdown_tb
